//--- rtl/mus_sched.sv
// rtl: peer-value fifo and the measurement update scheduler core
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// fifo with valid/ready on both sides
module mus_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clkEn,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wrPtr; // next write slot
   logic [AW-1:0] rdPtr; // next read slot
   wire push = inValid && inReady;
   wire pop = outValid && outReady;
   assign inReady = (level != DEPTH[AW:0]);
   assign outValid = (level != '0);
   assign outData = mem[rdPtr];

   // storage is written without reset, pointers carry the state
   always_ff @(posedge sys_clk) begin
      if (clkEn && push) begin
         mem[wrPtr] <= inData;
      end
   end

   // pointers and level
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         level <= '0;
      end else if (clkEn) begin
         if (push) wrPtr <= wrPtr + 1'b1;
         if (pop) rdPtr <= rdPtr + 1'b1;
         level <= level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // mus_fifo

// ==========================================================
// scheduler core
module mus_sched #(
   parameter int CYCLE_CLKS = mus_pkg::CYCLE_CLKS
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clkEn,
   // register port
   input wire mus_pkg::mus_req_t busReq,
   output logic [31:0] rdata,
   // start parameter set loaded and active
   input wire logic paramReady,
   // converter samples, unsynchronised pins
   input wire logic adcStrobe,
   input wire logic [15:0] adcData,
   // flag pins and the resulting one-hot commands
   input wire logic [7:0] flagPins,
   output logic [7:0] flagCmd,
   // digital inputs and outputs
   input wire logic [7:0] dinPins,
   output logic [7:0] dinValue,
   input wire logic [7:0] doutRequest,
   output logic [7:0] doutPins,
   // inter-device bus
   input wire logic peerRxValid,
   output logic peerRxReady,
   input wire logic [15:0] peerRxData,
   output logic peerTxValid,
   output logic [15:0] peerTxData,
   // fieldbus paths
   input wire logic fbInValid,
   input wire logic [15:0] fbInData,
   output logic [15:0] fbValue,
   output logic fbOutValid,
   output logic [15:0] fbOutData,
   // analog output
   input wire logic aoutSrcInvalid,
   output mus_pkg::mus_aout_t aout,
   // client connections
   input wire logic connOpen,
   input wire logic connClose,
   output logic connAccept,
   output logic connReject,
   output logic [1:0] connCount
);
   // ==========================================================
   // stage tick counters
   localparam int NT = 4;
   localparam int PER [NT] = '{mus_pkg::STAGE1_CLKS, mus_pkg::AOUT_CLKS,
                               mus_pkg::FB_STAGE_CLKS, CYCLE_CLKS};
   logic [NT-1:0] tick; // one-cycle strobes: stage1, analog, fieldbus, cycle
   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tick
         logic [15:0] cnt; // counts down to the next strobe
         assign tick[gi] = clkEn && (cnt == 16'h0000);
         always_ff @(posedge sys_clk) begin
            if (reset) cnt <= 16'h0000;
            else if (clkEn) cnt <= (cnt == 16'h0000) ? 16'(PER[gi] - 1) : cnt - 16'h0001;
         end
      end
   endgenerate
   wire s1Tick = tick[0];
   wire aoTick = tick[1];
   wire fbTick = tick[2];
   wire cycTick = tick[3];

   // lowest set bit of a vector: first flag in service order
   function automatic logic [7:0] firstBit(input logic [7:0] v);
      return v & (~v + 8'h01);
   endfunction

   // ==========================================================
   // pin synchronisers, second stage only is read
   logic [17:0] adcMeta, adcSync;
   logic [15:0] pinMeta, pinSync;
   logic adcSeen; // previous synchronised strobe level
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {adcMeta, adcSync, pinMeta, pinSync} <= '0;
         adcSeen <= 1'b0;
      end else if (clkEn) begin
         adcMeta <= {adcStrobe, 1'b0, adcData};
         adcSync <= adcMeta;
         pinMeta <= {flagPins, dinPins};
         pinSync <= pinMeta;
         adcSeen <= adcSync[17];
      end
   end
   wire adcEdge = adcSync[17] && !adcSeen;
   wire [7:0] flagSync = pinSync[15:8];

   // ==========================================================
   // registers
   logic initDone; // start parameter set active
   logic aoutActive, substEn;
   logic [1:0] aoutSel;
   logic [7:0] doutInv;
   logic [15:0] substVal;
   logic [4:0] fifoLevel;
   logic [15:0] stage1Value, peerValue;
   wire wrCtrl = busReq.wr && (busReq.addr == mus_pkg::REG_CTRL);
   wire wrInv = busReq.wr && (busReq.addr == mus_pkg::REG_DOUT_INV);
   wire wrSubst = busReq.wr && (busReq.addr == mus_pkg::REG_SUBST);
   logic [31:0] readMux;
   always_comb begin
      case (busReq.addr)
         mus_pkg::REG_CTRL: readMux = {28'h0000000, aoutSel, substEn, aoutActive};
         mus_pkg::REG_DOUT_INV: readMux = {24'h000000, doutInv};
         mus_pkg::REG_SUBST: readMux = {16'h0000, substVal};
         mus_pkg::REG_STATUS: readMux = {24'h000000, fifoLevel, connCount, initDone};
         mus_pkg::REG_VALUES: readMux = {peerValue, stage1Value};
         default: readMux = 32'h00000000; // unmapped reads as zero
      endcase
   end

   // configuration writes and read data, which stands one cycle only
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aoutActive <= mus_pkg::CTRL_ACTIVE_RST;
         substEn <= mus_pkg::CTRL_SUBST_RST;
         aoutSel <= mus_pkg::CTRL_SEL_RST;
         doutInv <= mus_pkg::DOUT_INV_RST;
         substVal <= mus_pkg::SUBST_RST;
         rdata <= 32'h00000000;
      end else if (clkEn) begin
         if (wrCtrl) begin
            aoutActive <= busReq.wdata[mus_pkg::CTRL_ACTIVE_BIT];
            substEn <= busReq.wdata[mus_pkg::CTRL_SUBST_BIT];
            aoutSel <= busReq.wdata[mus_pkg::CTRL_SEL_LSB +: 2];
         end
         if (wrInv) doutInv <= busReq.wdata[7:0];
         if (wrSubst) substVal <= busReq.wdata[15:0];
         rdata <= busReq.rd ? readMux : 32'h00000000;
      end
   end

   // init is sticky once the parameter loader reports ready
   always_ff @(posedge sys_clk) begin
      if (reset) initDone <= 1'b0;
      else if (clkEn && paramReady) initDone <= 1'b1;
   end

   // ==========================================================
   // stage one: samples wait for the next stage strobe
   logic [15:0] adcHold, aoutStage1;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {adcHold, stage1Value, aoutStage1} <= '0;
      end else if (clkEn) begin
         if (adcEdge) adcHold <= adcSync[15:0];
         if (s1Tick) stage1Value <= adcHold;
         if (s1Tick) aoutStage1 <= stage1Value;
      end
   end

   // ==========================================================
   // peer bus receive fifo, drained each cycle
   typedef enum logic [1:0] {ST_IDLE, ST_FLAGS, ST_DRAIN} mus_state_t;
   mus_state_t state, next_state;
   logic [7:0] flagPrev, pendFlags;
   logic peerValid;
   logic [15:0] peerData;
   wire peerPop = (state == ST_DRAIN);
   mus_fifo #(.WIDTH(mus_pkg::VAL_W), .DEPTH(mus_pkg::PEER_FIFO_DEPTH)) u_peer_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .clkEn(clkEn),
      .inValid(peerRxValid),
      .inReady(peerRxReady),
      .inData(peerRxData),
      .outValid(peerValid),
      .outReady(peerPop),
      .outData(peerData),
      .level(fifoLevel)
   );

   // ==========================================================
   // cycle sequencer: flags, then peer values
   always_comb begin
      case (state)
         ST_IDLE: next_state = (cycTick && initDone) ? ST_FLAGS : ST_IDLE;
         ST_FLAGS: next_state = (pendFlags == 8'h00) ? ST_DRAIN : ST_FLAGS;
         ST_DRAIN: next_state = peerValid ? ST_DRAIN : ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // flag capture and ordered service, one command per clock
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= ST_IDLE;
         {flagPrev, pendFlags, flagCmd} <= '0;
         peerValue <= 16'h0000;
      end else if (clkEn) begin
         state <= next_state;
         flagCmd <= 8'h00;
         if (state == ST_IDLE && cycTick && initDone) begin
            pendFlags <= flagSync ^ flagPrev;
            flagPrev <= flagSync;
         end
         if (state == ST_FLAGS) begin
            flagCmd <= firstBit(pendFlags);
            pendFlags <= pendFlags & ~firstBit(pendFlags);
         end
         if (peerPop && peerValid) peerValue <= peerData;
      end
   end

   // ==========================================================
   // 1 ms work: inputs, calculations, outputs, peer transmit
   logic [15:0] calcValue;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {dinValue, doutPins, calcValue, peerTxData} <= '0;
         peerTxValid <= 1'b0;
      end else if (clkEn) begin
         peerTxValid <= cycTick && initDone;
         if (!initDone) begin
            dinValue <= 8'h00;
            doutPins <= 8'h00;
         end else if (cycTick) begin
            dinValue <= pinSync[7:0];
            calcValue <= fbValue;
            peerTxData <= stage1Value;
            doutPins <= doutRequest ^ doutInv;
         end
      end
   end

   // ==========================================================
   // fieldbus: three-stage input pipe and one-stage output
   logic [15:0] fbPipe [mus_pkg::FB_STAGES];
   logic [15:0] fbLatch;
   assign fbValue = fbPipe[mus_pkg::FB_STAGES-1];
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < mus_pkg::FB_STAGES; i++) fbPipe[i] <= 16'h0000;
         fbLatch <= 16'h0000;
         fbOutValid <= 1'b0;
         fbOutData <= 16'h0000;
      end else if (clkEn) begin
         if (fbInValid) fbLatch <= fbInData;
         fbOutValid <= fbTick && initDone;
         if (fbTick) begin
            fbPipe[0] <= fbLatch;
            for (int i = 1; i < mus_pkg::FB_STAGES; i++) fbPipe[i] <= fbPipe[i-1];
            fbOutData <= stage1Value;
         end
      end
   end

   // ==========================================================
   // analog output: source select, substitute, refresh
   wire [15:0] srcValue = (aoutSel == mus_pkg::SEL_STAGE1) ? aoutStage1 :
                          (aoutSel == mus_pkg::SEL_FIELDBUS) ? fbValue :
                          (aoutSel == mus_pkg::SEL_CALC) ? calcValue : peerValue;
   wire useSubst = aoutSrcInvalid && substEn;
   wire [15:0] next_aout = useSubst ? substVal : srcValue;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aout <= '0;
      end else if (clkEn) begin
         aout.oe <= initDone && aoutActive;
         aout.strobe <= aoTick && initDone && aoutActive;
         if (!initDone || !aoutActive) aout.data <= 16'h0000;
         else if (aoTick) aout.data <= next_aout;
      end
   end

   // ==========================================================
   // client connection budget; a simultaneous open and close nets out
   wire full = (connCount == 2'(mus_pkg::CONN_MAX));
   wire canOpen = connOpen && (!full || connClose);
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         connCount <= 2'h0;
         connAccept <= 1'b0;
         connReject <= 1'b0;
      end else if (clkEn) begin
         connAccept <= canOpen;
         connReject <= connOpen && !canOpen;
         if (canOpen && !(connClose && connCount != 2'h0)) connCount <= connCount + 2'h1;
         else if (!canOpen && connClose && connCount != 2'h0) connCount <= connCount - 2'h1;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [15:0] sinceTx; // clocks since the last peer transmit
   always_ff @(posedge sys_clk) begin
      if (reset || peerTxValid) sinceTx <= 16'h0000;
      else if (sinceTx != 16'hffff) sinceTx <= sinceTx + 16'h0001;
   end
   sequence cycleStart;
      clkEn && cycTick && initDone && state == ST_IDLE;
   endsequence
   sequence flagsDone;
      state == ST_DRAIN;
   endsequence

   AST_FLAG_ORDER: assert property ((flagCmd != 8'h00) |-> $onehot(flagCmd) && flagCmd > $past(flagCmd))
      else $error("flag command not one-hot");
   AST_DRAIN_BOUND: assert property (cycleStart ##1 clkEn[*8] |-> ##[0:40] state == ST_IDLE)
      else $error("peer values not settled within the cycle");
   AST_DOUT_FOLLOW: assert property (cycleStart ##1 clkEn |-> doutPins == ($past(doutRequest) ^ $past(doutInv)))
      else $error("digital output did not follow decision");
   AST_PRE_INIT: assert property (!initDone |-> doutPins == 8'h00 && aout.data == 16'h0000 && !aout.oe)
      else $error("outputs driven before init");
   AST_HIGH_Z: assert property (clkEn && !aoutActive |=> !aout.oe)
      else $error("inactive analog output driven");
   AST_SUBST: assert property (clkEn && aoTick && initDone && aoutActive && useSubst |=> aout.data == $past(substVal))
      else $error("substitute value not output");
   AST_PEER_RATE: assert property (peerTxValid |-> sinceTx >= 16'(CYCLE_CLKS - 1) || $past(reset, 2))
      else $error("peer values sent too often");
   AST_CONN_MAX: assert property (clkEn && connOpen && !connClose && full |=> connReject && !connAccept && full)
      else $error("client limit exceeded");
   AST_FLAG_THEN_DRAIN: assert property (cycleStart |=> (state == ST_FLAGS) ##[1:9] flagsDone)
      else $error("flag service overran");
endmodule // mus_sched

`default_nettype wire

//--- common/mus_pkg.sv
// package: constants, register map and carrier types of the measurement update scheduler
package mus_pkg;
   // ==========================================================
   // clock and stage timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int CLK_RATE_HZ = 10_000_000;
   localparam int CYCLE_TIME_NS = 1_000_000;
   localparam int CYCLE_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS;
   localparam int STAGE1_TIME_NS = 52_000;
   localparam int STAGE1_CLKS = STAGE1_TIME_NS / CLK_PERIOD_NS;
   localparam int AOUT_RATE_HZ = 19_200;
   localparam int AOUT_CLKS = CLK_RATE_HZ / AOUT_RATE_HZ;
   localparam int FB_STAGE_TIME_NS = 250_000;
   localparam int FB_STAGE_CLKS = FB_STAGE_TIME_NS / CLK_PERIOD_NS;
   localparam int DOUT_MAX_TIME_NS = 250_000;
   localparam int DOUT_MAX_CLKS = DOUT_MAX_TIME_NS / CLK_PERIOD_NS;
   localparam int FB_STAGES = 3;
   localparam int CONN_MAX = 3;
   localparam int PEER_FIFO_DEPTH = 16;
   localparam int VAL_W = 16;
   // ==========================================================
   // register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DOUT_INV = 8'h04;
   localparam logic [7:0] REG_SUBST = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_VALUES = 8'h10;
   localparam int CTRL_ACTIVE_BIT = 0;
   localparam int CTRL_SUBST_BIT = 1;
   localparam int CTRL_SEL_LSB = 2;
   localparam logic CTRL_ACTIVE_RST = 1'b1;
   localparam logic CTRL_SUBST_RST = 1'b0;
   localparam logic [1:0] CTRL_SEL_RST = 2'h0;
   localparam logic [7:0] DOUT_INV_RST = 8'h00;
   // output code standing for 11 V on the analog output scale
   localparam logic [15:0] SUBST_RST = 16'h7333;
   // analog source selection codes
   localparam logic [1:0] SEL_STAGE1 = 2'h0;
   localparam logic [1:0] SEL_FIELDBUS = 2'h1;
   localparam logic [1:0] SEL_CALC = 2'h2;
   localparam logic [1:0] SEL_PEER = 2'h3;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } mus_req_t;
   typedef struct packed {
      logic [15:0] data;
      logic oe;
      logic strobe;
   } mus_aout_t;
endpackage

//--- tb/mus_far_model.sv
// tb: far-side model, a peer amplifier feeding the peer fifo and a fieldbus master
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// peer amplifier and fieldbus master
module mus_far_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // peer bus side
   output logic peerRxValid,
   input wire logic peerRxReady,
   output logic [15:0] peerRxData,
   // fieldbus master side
   output logic fbInValid,
   output logic [15:0] fbInData
);
   // idle: nothing offered, data lines carry junk rather than a stale word
   initial begin
      peerRxValid = 1'b0;
      peerRxData = 16'h5555;
      fbInValid = 1'b0;
      fbInData = 16'haaaa;
   end

   // offer n words back to back, each held until ready is sampled high
   task automatic peer_send(input int n, input logic [15:0] base);
      @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         peerRxValid <= 1'b1;
         peerRxData <= base + 16'(i);
         @(posedge sys_clk);
         while (peerRxReady !== 1'b1 && !reset)
            @(posedge sys_clk);
      end
      // released: inverse of the last word, so it cannot pass for data
      peerRxValid <= 1'b0;
      peerRxData <= ~(base + 16'(n - 1));
   endtask

   // master writes one value for one cycle, then the line goes to junk
   task automatic fb_send(input logic [15:0] v);
      @(posedge sys_clk);
      fbInValid <= 1'b1;
      fbInData <= v;
      @(posedge sys_clk);
      fbInValid <= 1'b0;
      fbInData <= ~v;
   endtask
endmodule // mus_far_model
`default_nettype wire

//--- tb/mus_sched_tb_top.sv
// tb: self-checking bench of the measurement update scheduler
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// bench top
module mus_sched_tb_top;
   localparam int CYC = 200; // shortened 1 ms cycle, keeps the run short
   // design signals
   logic sys_clk, reset, clkEn, paramReady, adcStrobe, aoutSrcInvalid;
   logic connOpen, connClose, connAccept, connReject, peerRxValid, peerRxReady;
   logic peerTxValid, fbInValid, fbOutValid;
   logic [1:0] connCount;
   logic [7:0] flagPins, flagCmd, dinPins, dinValue, doutRequest, doutPins;
   logic [15:0] adcData, peerRxData, peerTxData, fbInData, fbValue, fbOutData;
   logic [31:0] rdata, v;
   mus_pkg::mus_req_t busReq;
   mus_pkg::mus_aout_t aout;
   // bench bookkeeping
   int badCount, compares, accN, rejN, n;
   logic [7:0] flagQ[$];
   wire logic [2:0] pulses = {fbOutValid, aout.strobe, peerTxValid};

   mus_sched #(.CYCLE_CLKS(CYC)) dut_u (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
      .busReq(busReq), .rdata(rdata), .paramReady(paramReady), .adcStrobe(adcStrobe),
      .adcData(adcData), .flagPins(flagPins), .flagCmd(flagCmd), .dinPins(dinPins),
      .dinValue(dinValue), .doutRequest(doutRequest), .doutPins(doutPins),
      .peerRxValid(peerRxValid), .peerRxReady(peerRxReady), .peerRxData(peerRxData),
      .peerTxValid(peerTxValid), .peerTxData(peerTxData), .fbInValid(fbInValid),
      .fbInData(fbInData), .fbValue(fbValue), .fbOutValid(fbOutValid),
      .fbOutData(fbOutData), .aoutSrcInvalid(aoutSrcInvalid), .aout(aout),
      .connOpen(connOpen), .connClose(connClose), .connAccept(connAccept),
      .connReject(connReject), .connCount(connCount));
   mus_far_model far_u (.sys_clk(sys_clk), .reset(reset), .peerRxValid(peerRxValid),
      .peerRxReady(peerRxReady), .peerRxData(peerRxData), .fbInValid(fbInValid),
      .fbInData(fbInData));

   // 100 ns clock
   always #50 sys_clk = ~sys_clk;

   // pulse monitors: registered one-cycle outputs, counted once each
   always @(posedge sys_clk) begin
      if (flagCmd !== 8'h00)
         flagQ.push_back(flagCmd);
      if (connAccept === 1'b1)
         accN++;
      if (connReject === 1'b1)
         rejN++;
   end

   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge sys_clk);
      busReq.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge sys_clk);
      busReq.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask
   // clocks until the next pulse of tick k (0 cycle, 1 analog, 2 fieldbus), bounded
   task automatic waitp(input int k, output int c);
      c = 0;
      do begin
         @(posedge sys_clk);
         #1 c++;
      end while (pulses[k] !== 1'b1 && c < 3000);
      // a pulse that never comes is a mismatch, not a silent pass
      if (c >= 3000)
         chk("pulseTimeout", 0, 1);
   endtask
   task automatic closeOut();
      if (badCount == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // watchdog: the whole sequence needs about 20300 clocks
   initial begin
      repeat (40000) @(posedge sys_clk);
      badCount++;
      closeOut();
   end

   // ==========================================================
   // main sequence
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      clkEn = 1'b1;
      busReq = '0;
      paramReady = 1'b0;
      adcStrobe = 1'b0;
      adcData = 16'h0000;
      flagPins = 8'h00;
      dinPins = 8'h3c;
      doutRequest = 8'h5a;
      aoutSrcInvalid = 1'b0;
      connOpen = 1'b0;
      connClose = 1'b0;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      // before start parameters: outputs held at zero
      repeat (300) @(posedge sys_clk);
      chk("doutPins", 0, doutPins);
      chk("aoutOe", 0, aout.oe);
      chk("aoutData", 0, aout.data);
      rdc("status", mus_pkg::REG_STATUS, 0);
      rdc("ctrl", mus_pkg::REG_CTRL, 32'h0000_0001);
      rdc("doutInv", mus_pkg::REG_DOUT_INV, 0);
      rdc("subst", mus_pkg::REG_SUBST, 32'h0000_7333);
      rdc("unmapped", 8'h20, 0);
      paramReady <= 1'b1;
      waitp(0, n);
      chk("doutPins", 8'h5a, doutPins);
      chk("aoutOe", 1, aout.oe);
      waitp(0, n);
      chk("cyclePeriod", CYC, n);
      chk("dinValue", 8'h3c, dinValue);
      waitp(1, n);
      waitp(1, n);
      chk("aoutPeriod", mus_pkg::AOUT_CLKS, n);
      // inversion takes effect on the clock after the next tick
      wr(mus_pkg::REG_DOUT_INV, 32'h0000_00ff);
      waitp(0, n);
      chk("doutPins", 8'ha5, doutPins);
      // all eight flags change at once: served lowest first
      flagPins <= 8'hff;
      waitp(0, n);
      flagQ.delete();
      waitp(0, n);
      repeat (20) @(posedge sys_clk);
      chk("flagCount", 8, flagQ.size());
      for (int i = 0; i < 8; i++)
         chk("flagCmd", 8'h01 << i, (i < flagQ.size()) ? flagQ[i] : 8'h00);
      // fill the peer fifo until it refuses, then let the next cycle drain it
      far_u.peer_send(16, 16'h1000);
      #1 chk("peerRxReady", 0, peerRxReady);
      rd(mus_pkg::REG_STATUS, v);
      chk("fifoLevel", 16, v[7:3]);
      waitp(0, n);
      repeat (20) @(posedge sys_clk);
      rd(mus_pkg::REG_VALUES, v);
      chk("peerValue", 16'h100f, v[31:16]);
      rd(mus_pkg::REG_STATUS, v);
      chk("fifoLevel", 0, v[7:3]);
      // converter sample through stage one to the analog output
      adcData <= 16'h0abc;
      adcStrobe <= 1'b1;
      repeat (5) @(posedge sys_clk);
      adcStrobe <= 1'b0;
      repeat (3) waitp(1, n);
      rd(mus_pkg::REG_VALUES, v);
      chk("stage1Value", 16'h0abc, v[15:0]);
      chk("aoutData", 16'h0abc, aout.data);
      // invalid source: substitution off by default, then on
      aoutSrcInvalid <= 1'b1;
      waitp(1, n);
      chk("aoutData", 16'h0abc, aout.data);
      wr(mus_pkg::REG_CTRL, 32'h0000_0003);
      repeat (2) waitp(1, n);
      chk("aoutData", 16'h7333, aout.data);
      wr(mus_pkg::REG_SUBST, 32'h0000_1234);
      repeat (2) waitp(1, n);
      chk("aoutData", 16'h1234, aout.data);
      aoutSrcInvalid <= 1'b0;
      wr(mus_pkg::REG_CTRL, 32'h0000_0000);
      // an inactive output gives no refresh strobe, so count clocks instead
      repeat (2) @(posedge sys_clk);
      #1 chk("aoutOe", 0, aout.oe);
      chk("aoutData", 0, aout.data);
      wr(mus_pkg::REG_CTRL, 32'h0000_0001);
      // fieldbus output stage and peer transmit carry the stage-one value
      waitp(2, n);
      waitp(2, n);
      chk("fbOutPeriod", mus_pkg::FB_STAGE_CLKS, n);
      chk("fbOutData", 16'h0abc, fbOutData);
      waitp(0, n);
      chk("peerTxData", 16'h0abc, peerTxData);
      // fieldbus input needs three 250 us stages, never fewer
      far_u.fb_send(16'hbeef);
      repeat (4900) @(posedge sys_clk);
      #1 chk("fbValueEarly", 0, fbValue);
      n = 0;
      while (fbValue !== 16'hbeef && n < 2700) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk("fbValue", 16'hbeef, fbValue);
      // through the calculation channel to the analog output
      wr(mus_pkg::REG_CTRL, 32'h0000_0009);
      repeat (2) waitp(0, n);
      waitp(1, n);
      chk("aoutCalc", 16'hbeef, aout.data);
      // peer source, then the fieldbus source straight from the input pipe
      wr(mus_pkg::REG_CTRL, 32'h0000_000d);
      repeat (2) waitp(1, n);
      chk("aoutPeer", 16'h100f, aout.data);
      wr(mus_pkg::REG_CTRL, 32'h0000_0005);
      repeat (2) waitp(1, n);
      chk("aoutFieldbus", 16'hbeef, aout.data);
      // five opens: four accepted, one rejected; a close frees a place for the fifth
      for (int i = 0; i < 5; i++) begin
         if (i == 4) begin
            connClose <= 1'b1;
            @(posedge sys_clk);
            connClose <= 1'b0;
            repeat (3) @(posedge sys_clk);
            #1 chk("connCount", 2, connCount);
         end
         connOpen <= 1'b1;
         @(posedge sys_clk);
         connOpen <= 1'b0;
         repeat (3) @(posedge sys_clk);
         if (i == 3)
            #1 chk("connCount", 3, connCount);
      end
      chk("accepts", 4, accN);
      chk("rejects", 1, rejN);
      closeOut();
   end
endmodule // mus_sched_tb_top
`default_nettype wire
